// ### sadc_ctrl.sv
// Conversion sequencer, control registers and bus port of the converter.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [DATA_W-1:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [DATA_W-1:0] busRdata,
    input wire logic compIn,
    output logic [RES_W-1:0] trialCode,
    output logic [3:0] chanSel,
    output logic sampleHold,
    output logic ladderConnect,
    output logic convBusy,
    output logic convDoneIrq
);
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic compMeta;
        logic compSync;
        sadc_state_t state;
        logic [1:0] divCnt;
        logic [5:0] sampCnt;
        logic [1:0] slot;
        logic [3:0] bitIdx;
        logic [RES_W-1:0] trial;
        logic [2:0] curChan;
        logic [2:0] emphChan;
        logic [3:0] chanOut;
        logic sampleHold;
        logic busy;
        logic irq;
    } sadc_ctrl_st_t;

    sadc_ctrl_st_t s;
    sadc_ctrl_st_t n;

    logic tick;
    logic ctl0Write;
    logic startNow;
    logic abortNow;
    logic restart;
    logic memWr;
    logic [RES_W-1:0] memData;
    logic [7:0] altByte;
    sadc_mode_t modeSel;
    sadc_mode_t modeNew;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] divLimit(input logic [1:0] sel);
        case (sel)
            DIV_1: divLimit = 2'h0;
            DIV_2: divLimit = 2'h1;
            default: divLimit = 2'h3;
        endcase
    endfunction

    function automatic logic [5:0] convTicks(input logic res10, input logic sh);
        if (sh) begin
            convTicks = res10 ? CONV_10_SH : CONV_8_SH;
        end else begin
            convTicks = res10 ? CONV_10_NOSH : CONV_8_NOSH;
        end
    endfunction

    function automatic logic [5:0] sampTicks(input logic res10, input logic sh);
        sampTicks = convTicks(res10, sh) - (res10 ? SAR_TICKS_10 : SAR_TICKS_8);
    endfunction

    function automatic logic [2:0] nextEmph(input logic [2:0] e);
        nextEmph = (e == 3'h7) ? 3'h1 : e + 3'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        modeSel = sadc_mode_t'(s.ctrl0[MODE_LSB +: 3]);
        modeNew = sadc_mode_t'(busWdata[MODE_LSB +: 3]);
        // Divider runs from the converter source clock, which is clk itself.
        tick = (s.divCnt == divLimit(s.ctrl1[DIV_LSB +: 2]));
        n.divCnt = tick ? 2'h0 : s.divCnt + 2'h1;
        ctl0Write = busWr && (busAddr == OFS_CTRL0);
        startNow = ctl0Write && busWdata[START_BIT] && !s.ctrl0[START_BIT];
        abortNow = ctl0Write && !busWdata[START_BIT] && (s.state != ST_IDLE);
        restart = 1'b0;
        memWr = 1'b0;
        n.compMeta = compIn;
        n.compSync = s.compMeta;
        n.irq = 1'b0;

        if (busWr) begin
            case (busAddr)
                OFS_CTRL0: n.ctrl0 = busWdata;
                OFS_CTRL1: n.ctrl1 = busWdata;
                OFS_CTRL2: n.ctrl2 = busWdata;
                default: ;
            endcase
        end

        case (s.state)
            ST_IDLE: begin
                if (startNow) begin
                    restart = 1'b1;
                    n.divCnt = 2'h0;
                    n.emphChan = 3'h0;
                    if (modeNew == MODE_ONESHOT || modeNew == MODE_REPEAT) begin
                        n.curChan = busWdata[CH_LSB +: 3];
                    end else begin
                        n.curChan = 3'h0;
                    end
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    if (s.sampCnt == 6'h01) begin
                        n.state = ST_BITS;
                        n.trial = '0;
                        n.trial[MSB_IDX] = 1'b1;
                        n.bitIdx = MSB_IDX;
                        n.slot = 2'h0;
                    end else begin
                        n.sampCnt = s.sampCnt - 6'h01;
                    end
                end
            end
            ST_BITS: begin
                if (tick) begin
                    if (s.slot == SLOT_LAST) begin
                        n.slot = 2'h0;
                        n.trial[s.bitIdx] = s.compSync;
                        // Eight-bit runs stop two bits early, leaving a left-aligned code.
                        if (s.bitIdx == (s.ctrl1[RES10_BIT] ? STOP_IDX_10 : STOP_IDX_8)) begin
                            memWr = 1'b1;
                        end else begin
                            n.bitIdx = s.bitIdx - 4'h1;
                            n.trial[s.bitIdx - 4'h1] = 1'b1;
                        end
                    end else begin
                        n.slot = s.slot + 2'h1;
                    end
                end
            end
            default: n.state = ST_IDLE;
        endcase

        if (s.ctrl1[RES10_BIT]) begin
            memData = n.trial;
        end else begin
            memData = {2'h0, n.trial[9:2]};
        end

        if (memWr) begin
            case (modeSel)
                MODE_ONESHOT: begin
                    n.state = ST_IDLE;
                    n.irq = 1'b1;
                end
                MODE_REPEAT: begin
                    restart = 1'b1;
                end
                MODE_SSWEEP: begin
                    if (s.curChan == s.ctrl0[CH_LSB +: 3]) begin
                        n.state = ST_IDLE;
                        n.irq = 1'b1;
                    end else begin
                        n.curChan = s.curChan + 3'h1;
                        restart = 1'b1;
                    end
                end
                MODE_RSWEEP0: begin
                    // The second group has five inputs, so upper results hold junk.
                    n.curChan = (s.curChan == s.ctrl0[CH_LSB +: 3]) ? 3'h0 : s.curChan + 3'h1;
                    restart = 1'b1;
                end
                MODE_RSWEEP1: begin
                    if (s.curChan != 3'h0) begin
                        n.curChan = 3'h0;
                    end else begin
                        n.emphChan = nextEmph(s.emphChan);
                        n.curChan = nextEmph(s.emphChan);
                    end
                    restart = 1'b1;
                end
                default: n.state = ST_IDLE;
            endcase
            // A software write in the same cycle keeps its own value of the flag.
            if (n.state == ST_IDLE && !ctl0Write) begin
                n.ctrl0[START_BIT] = 1'b0;
            end
        end

        if (restart) begin
            n.state = ST_SAMPLE;
            n.sampCnt = sampTicks(s.ctrl1[RES10_BIT], s.ctrl2[SH_BIT]);
            n.trial = '0;
        end

        if (abortNow) begin
            n.state = ST_IDLE;
            n.irq = 1'b0;
            memWr = 1'b0;
            restart = 1'b0;
        end

        // Second group reuses the channel index and its result slot.
        n.chanOut = {s.ctrl1[GROUP_BIT], n.curChan};
        n.sampleHold = (n.state == ST_SAMPLE) && s.ctrl2[SH_BIT];
        n.busy = (n.state != ST_IDLE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ctrl0 <= CTRL0_RST;
            s.ctrl1 <= CTRL1_RST;
            s.ctrl2 <= CTRL2_RST;
            s.state <= ST_IDLE;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (busAddr)
            OFS_CTRL0: altByte = s.ctrl0;
            OFS_CTRL1: altByte = s.ctrl1;
            OFS_CTRL2: altByte = s.ctrl2;
            OFS_STATUS: altByte = {4'h0, s.curChan, s.busy};
            default: altByte = 8'h00;
        endcase
    end

    sadc_result_mem u_mem (
        .clk(clk),
        .arst_n(arst_n),
        .wrEn(memWr),
        .wrIdx(s.curChan),
        .wrData(memData),
        .rdEn(busRd),
        .rdIdx(busAddr[3:1]),
        .rdHigh(busAddr[0]),
        .rdAlt(busAddr >= RESULT_SPAN),
        .altByte(altByte),
        .rdData(busRdata)
    );

    assign trialCode = s.trial;
    assign chanSel = s.chanOut;
    assign sampleHold = s.sampleHold;
    // Detaching the ladder while idle saves its standing current.
    assign ladderConnect = s.ctrl1[REFCON_BIT];
    assign convBusy = s.busy;
    assign convDoneIrq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Ticks seen in the running conversion, for the length checks only.
    logic [5:0] hTicks;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hTicks <= 6'h00;
        end else if (restart) begin
            hTicks <= 6'h00;
        end else if (tick && s.state != ST_IDLE) begin
            hTicks <= hTicks + 6'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_ladder;
        busWr && busAddr == OFS_CTRL1 |=> ladderConnect == $past(busWdata[REFCON_BIT]);
    endproperty
    a_ladder: assert property (p_ladder) else $error("ladder bit not followed");

    property p_start;
        startNow |=> convBusy ##1 convBusy;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_start_cause;
        $rose(convBusy) |-> $past(startNow);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without edge");

    property p_abort;
        abortNow |=> !convBusy && !convDoneIrq;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not immediate");

    property p_len_nosh;
        memWr && !s.ctrl2[SH_BIT] |-> hTicks == convTicks(s.ctrl1[RES10_BIT], 1'b0) - 6'h01;
    endproperty
    a_len_nosh: assert property (p_len_nosh) else $error("bad length without hold");

    property p_len_sh;
        memWr && s.ctrl2[SH_BIT] |-> hTicks == convTicks(s.ctrl1[RES10_BIT], 1'b1) - 6'h01;
    endproperty
    a_len_sh: assert property (p_len_sh) else $error("bad length with hold");

    property p_oneshot_end;
        memWr && modeSel == MODE_ONESHOT && !ctl0Write
            |=> convDoneIrq && !convBusy && !s.ctrl0[START_BIT];
    endproperty
    a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot end wrong");

    property p_irq_source;
        convDoneIrq |-> $past(memWr) && $past(modeSel) inside {MODE_ONESHOT, MODE_SSWEEP};
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("stray request");

    property p_repeat_runs;
        memWr && modeSel == MODE_REPEAT && !abortNow |=> convBusy && !convDoneIrq;
    endproperty
    a_repeat_runs: assert property (p_repeat_runs) else $error("repeat stopped");

    property p_chan_write;
        memWr && modeSel inside {MODE_ONESHOT, MODE_REPEAT} |-> s.curChan == s.ctrl0[2:0];
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("wrong result slot");

    property p_res8;
        memWr && !s.ctrl1[RES10_BIT] |-> memData == {2'h0, trialCode[9:3], s.compSync};
    endproperty
    a_res8: assert property (p_res8) else $error("eight-bit layout wrong");

    property p_div4;
        tick && s.ctrl1[DIV_LSB +: 2] == DIV_4 && !startNow |=> !tick ##1 !tick;
    endproperty
    a_div4: assert property (p_div4) else $error("quarter clock too fast");

    property p_hold;
        sampleHold |-> s.ctrl2[SH_BIT] && convBusy;
    endproperty
    a_hold: assert property (p_hold) else $error("hold without enable");
endmodule
`default_nettype wire

// ### sadc_pkg.sv
// Shared constants and types for the successive-approximation converter control.
`default_nettype none
package sadc_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RES_W = 10;
    localparam int unsigned NUM_CH = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Byte offsets. Result words occupy 16'h00..16'h0F, two bytes per channel.
    localparam logic [4:0] OFS_RESULT0 = 5'h00;
    localparam logic [4:0] RESULT_SPAN = 5'h10;
    localparam logic [4:0] OFS_CTRL0 = 5'h14;
    localparam logic [4:0] OFS_CTRL1 = 5'h15;
    localparam logic [4:0] OFS_CTRL2 = 5'h16;
    localparam logic [4:0] OFS_STATUS = 5'h17;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CH_LSB = 0;
    localparam int unsigned MODE_LSB = 3;
    localparam int unsigned START_BIT = 6;
    localparam int unsigned GROUP_BIT = 0;
    localparam int unsigned RES10_BIT = 3;
    localparam int unsigned REFCON_BIT = 5;
    localparam int unsigned DIV_LSB = 6;
    localparam int unsigned SH_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion lengths in conversion clock ticks: 49, 59, 28 and 33.
    localparam logic [5:0] CONV_8_NOSH = 6'h31;
    localparam logic [5:0] CONV_10_NOSH = 6'h3B;
    localparam logic [5:0] CONV_8_SH = 6'h1C;
    localparam logic [5:0] CONV_10_SH = 6'h21;
    // Each bit decision takes three ticks, which covers the two-stage comparator sync.
    localparam logic [5:0] SAR_TICKS_8 = 6'h18;
    localparam logic [5:0] SAR_TICKS_10 = 6'h1E;
    localparam logic [1:0] SLOT_LAST = 2'h2;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [3:0] STOP_IDX_8 = 4'h2;
    localparam logic [3:0] STOP_IDX_10 = 4'h0;

    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;

    typedef enum logic [2:0] {
        MODE_ONESHOT,
        MODE_REPEAT,
        MODE_SSWEEP,
        MODE_RSWEEP0,
        MODE_RSWEEP1
    } sadc_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_BITS
    } sadc_state_t;
endpackage
`default_nettype wire

// ### sadc_result_mem.sv
// Per-channel result store with a registered byte read port.
`default_nettype none
module sadc_result_mem
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [RES_W-1:0] wrData,
    input wire logic rdEn,
    input wire logic [2:0] rdIdx,
    input wire logic rdHigh,
    input wire logic rdAlt,
    input wire logic [7:0] altByte,
    output logic [7:0] rdData
);
    typedef struct packed {
        logic [NUM_CH-1:0][RES_W-1:0] words;
        logic [7:0] rdData;
    } sadc_mem_st_t;

    sadc_mem_st_t s;
    sadc_mem_st_t n;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        if (wrEn) begin
            n.words[wrIdx] = wrData;
        end
        // Read data stand for one cycle only, so an idle cycle returns zero.
        n.rdData = 8'h00;
        if (rdEn) begin
            if (rdAlt) begin
                n.rdData = altByte;
            end else if (rdHigh) begin
                n.rdData = {6'h00, s.words[rdIdx][9:8]};
            end else begin
                n.rdData = s.words[rdIdx][7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rdData = s.rdData;
endmodule
`default_nettype wire

// ### sadc_analog_model.sv
// Behavioural comparator and resistor ladder on the converter's analogue side.
`default_nettype none
module sadc_analog_model
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic [RES_W-1:0] trialCode,
    input wire logic ladderConnect,
    input wire logic [RES_W-1:0] level,
    input wire logic slow,
    output logic compIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fastCmp;
    logic slowCmp_q = 1'b0;
    logic noise_q = 1'b0;
    // A detached ladder has no reference, so the comparator only gives noise.
    assign fastCmp = ladderConnect ? (level >= trialCode) : noise_q;
    always @(posedge clk) begin
        noise_q <= ~noise_q;
    end
    // A slow comparator settles half a clock late, still ahead of the first sync stage.
    always @(negedge clk) begin
        slowCmp_q <= fastCmp;
    end
    // The input pins are only ever read here, never driven.
    assign compIn = slow ? slowCmp_q : fastCmp;
endmodule
`default_nettype wire

// ### sadc_ctrl_test.sv
// Self-checking bench for the converter control: bus, sequencing and results.
`default_nettype none
module sadc_ctrl_test
    import sadc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] div;
        logic res10;
        logic hold;
        logic grp;
        logic [2:0] ch;
        logic [9:0] lvl;
        logic [9:0] cyc;
    } sadc_row_t;
    logic clk, arst_n, busWr, busRd, compIn, sampleHold, ladderConnect, convBusy, convDoneIrq;
    logic slow;
    logic [4:0] busAddr;
    logic [7:0] busWdata, busRdata, rd, lowExp;
    logic [9:0] trialCode, level;
    logic [3:0] chanSel;
    int n_fail = 0;
    int tests_run = 0;
    int busyCnt, irqCnt, shCnt;
    sadc_row_t rows [6];
    sadc_row_t r;

    sadc_ctrl dut (.clk(clk), .arst_n(arst_n), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .compIn(compIn),
        .trialCode(trialCode), .chanSel(chanSel), .sampleHold(sampleHold),
        .ladderConnect(ladderConnect), .convBusy(convBusy), .convDoneIrq(convDoneIrq));
    sadc_analog_model analog (.clk(clk), .trialCode(trialCode), .ladderConnect(ladderConnect),
        .level(level), .slow(slow), .compIn(compIn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rdb(input logic [4:0] a);
        @(posedge clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        #1;
        rd = busRdata;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic waitIdle();
        @(negedge clk);
        for (int k = 0; k < 1000 && convBusy !== 1'b0; k++) @(negedge clk);
        cycles(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are counted at the falling edge, where they have long settled.
    always @(negedge clk) begin
        if (convBusy === 1'b1) busyCnt++;
        if (convDoneIrq === 1'b1) irqCnt++;
        if (sampleHold === 1'b1) shCnt++;
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400us;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b0;
        busAddr = 5'h00;
        busWdata = 8'h00;
        busWr = 1'b0;
        busRd = 1'b0;
        level = 10'h000;
        slow = 1'b0;
        rows = '{'{2'h0, 1'b0, 1'b0, 1'b0, 3'h0, 10'h2D7, 10'h031},
            '{2'h1, 1'b1, 1'b0, 1'b0, 3'h3, 10'h155, 10'h076},
            '{2'h2, 1'b0, 1'b1, 1'b0, 3'h7, 10'h3FF, 10'h070},
            '{2'h3, 1'b1, 1'b1, 1'b0, 3'h1, 10'h000, 10'h084},
            '{2'h0, 1'b1, 1'b1, 1'b0, 3'h5, 10'h201, 10'h021},
            '{2'h0, 1'b0, 1'b1, 1'b1, 3'h2, 10'h0C4, 10'h01C}};
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            level = r.lvl;
            slow = i[0];
            wr(OFS_CTRL1, {r.div, 2'b10, r.res10, 2'b00, r.grp});
            wr(OFS_CTRL2, {7'h00, r.hold});
            busyCnt = 0;
            irqCnt = 0;
            shCnt = 0;
            wr(OFS_CTRL0, {2'b01, MODE_ONESHOT, r.ch});
            cycles(1);
            check("chanSel", {6'h00, r.grp, r.ch}, {6'h00, chanSel});
            check("ladderConnect", 10'h001, {9'h000, ladderConnect});
            waitIdle();
            check("busy cycles", r.cyc, busyCnt[9:0]);
            check("irq pulses", 10'h001, irqCnt[9:0]);
            check("hold seen", {9'h000, r.hold}, {9'h000, shCnt != 0});
            rdb({1'b0, r.ch, 1'b0});
            lowExp = r.res10 ? r.lvl[7:0] : r.lvl[9:2];
            check("low byte", {2'h0, lowExp}, {2'h0, rd});
            rdb({1'b0, r.ch, 1'b1});
            check("high byte", r.res10 ? {8'h00, r.lvl[9:8]} : 10'h000, {2'h0, rd});
            rdb(OFS_CTRL0);
            check("start flag", 10'h000, {9'h000, rd[START_BIT]});
        end
        // Writing the control word without the flag, or again with it set, must not start.
        wr(OFS_CTRL1, 8'h28);
        wr(OFS_CTRL2, 8'h00);
        busyCnt = 0;
        irqCnt = 0;
        wr(OFS_CTRL0, 8'h04);
        cycles(10);
        check("busy without start", 10'h000, busyCnt[9:0]);
        wr(OFS_CTRL0, 8'h44);
        cycles(10);
        wr(OFS_CTRL0, 8'h44);
        waitIdle();
        check("busy after rewrite", 10'h03B, busyCnt[9:0]);
        check("one-shot irq", 10'h001, irqCnt[9:0]);
        // Abort in mid-conversion; slot zero must keep the first row's result.
        irqCnt = 0;
        wr(OFS_CTRL0, 8'h40);
        cycles(20);
        wr(OFS_CTRL0, 8'h00);
        @(negedge clk);
        check("busy after abort", 10'h000, {9'h000, convBusy});
        cycles(70);
        check("abort irq", 10'h000, irqCnt[9:0]);
        wr(OFS_RESULT0, 8'h5A);
        rdb(OFS_RESULT0);
        check("result kept", 10'h0B5, {2'h0, rd});
        wr(5'h1F, 8'hFF);
        rdb(5'h1F);
        check("unmapped", 10'h000, {2'h0, rd});
        // Repeat on channel six, with the input moved while it runs.
        level = 10'h123;
        wr(OFS_CTRL0, 8'h4E);
        cycles(200);
        check("repeat busy", 10'h001, {9'h000, convBusy});
        level = 10'h2EE;
        cycles(130);
        rdb(5'h0C);
        check("repeat low", 10'h0EE, {2'h0, rd});
        rdb(5'h0D);
        check("repeat high", 10'h002, {2'h0, rd});
        check("repeat irq", 10'h000, irqCnt[9:0]);
        wr(OFS_CTRL0, 8'h0E);
        cycles(2);
        check("repeat stop", 10'h000, {9'h000, convBusy});
        for (int m = 0; m < 5; m++) begin
            wr(OFS_CTRL0, {2'b01, m[2:0], 3'h3});
            cycles(2);
            check("mode busy", 10'h001, {9'h000, convBusy});
            check("first channel", (m < 2) ? 10'h003 : 10'h000, {7'h00, chanSel[2:0]});
            wr(OFS_CTRL0, 8'h00);
            cycles(2);
        end
        // An unused mode code converts once and idles without a request.
        irqCnt = 0;
        wr(OFS_CTRL0, 8'h68);
        waitIdle();
        check("spare mode irq", 10'h000, irqCnt[9:0]);
        rdb(OFS_CTRL0);
        check("spare mode flag", 10'h000, {9'h000, rd[START_BIT]});
        // A second reset while idle must detach the ladder and clear the registers.
        @(posedge clk);
        arst_n <= 1'b0;
        cycles(3);
        check("ladder in reset", 10'h000, {9'h000, ladderConnect});
        @(posedge clk);
        arst_n <= 1'b1;
        rdb(OFS_CTRL1);
        check("ctrl1 reset", 10'h000, {2'h0, rd});
        rdb(5'h0C);
        check("result reset", 10'h000, {2'h0, rd});
        tally_and_finish();
    end
endmodule
`default_nettype wire
